//--- design/can_rx_pkg.sv
//==========================================================================
// Functional notes
// [R1] Five-stage receive queue; only the head is visible.
// [R2] Each receive buffer holds fifteen bytes.
// [R3] Full flag marks an accepted frame at head.
// [R4] Background buffer filled while filter evaluates.
// [R5] Accepted frame queued, flag set, interrupt unless masked.
// [R6] Software reads head, then clears flag to release.
// [R7] Back-to-back frames go into background buffer.
// [R8] Rejected or faulty frames are never queued.
// [R9] Own frames not queued except in loopback.
// [R10] Lost arbitration continues as ordinary receiver.
// [R11] Accepted frame into full queue raises overrun.
// [R12] Full queue drops frames until space frees.
// [R13] Pattern registers with per-bit don't-care masks.
// [R14] Hit index reports lowest matching filter.
// [R15] Thirty-two bit mode: two filters, banks.
// [R16] Sixteen bit mode: four filters, two per bank.
// [R17] Eight bit mode: eight byte filters.
// [R18] Closed mode never sets the full flag.
// [R19] Error counters are read-only.
// [R20] Configuration writable only in acknowledged init mode.
// [R21] Transmit pin forced recessive in init or power-down.
// [R22] Module enable bit accepts one write only.
// [R23] Init acknowledge follows request once settled.
// [R24] Mask one ignores bit; queue is oldest first.
//==========================================================================
package can_rx_pkg;

	// Structure sizes.
	localparam int FIFO_DEPTH = 5;
	localparam int BUF_BYTES  = 15;
	localparam int TS_HI_BYTE = 13;
	localparam int TS_LO_BYTE = 14;
	localparam int ADDR_W     = 8;

	// Register byte addresses.
	localparam logic [7:0] CTL0_ADDR   = 8'h00;
	localparam logic [7:0] CTL1_ADDR   = 8'h04;
	localparam logic [7:0] BTR0_ADDR   = 8'h08;
	localparam logic [7:0] BTR1_ADDR   = 8'h0C;
	localparam logic [7:0] RFLG_ADDR   = 8'h10;
	localparam logic [7:0] IDAC_ADDR   = 8'h14;
	localparam logic [7:0] ERRC_ADDR   = 8'h18;
	localparam logic [7:0] PAT_BASE    = 8'h20;
	localparam logic [7:0] MASK_BASE   = 8'h40;
	localparam logic [7:0] FG_BASE     = 8'h60;
	localparam logic [7:0] FG_LAST     = 8'h98;

	// Field positions.
	localparam int CTL0_INIT_REQ = 0;
	localparam int CTL0_PWR_DOWN = 1;
	localparam int CTL0_RX_IE    = 2;
	localparam int CTL0_OVR_IE   = 3;
	localparam int CTL1_INIT_ACK = 0;
	localparam int CTL1_TS_EN    = 3;
	localparam int CTL1_LOOPBACK = 5;
	localparam int CTL1_ENABLE   = 7;
	localparam int RFLG_RX_FULL  = 0;
	localparam int RFLG_OVERRUN  = 1;
	localparam int IDAC_MODE_LO  = 4;

	// Reset values.
	localparam logic [7:0] CTL0_RESET = 8'h01;
	localparam logic [7:0] CTL1_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET  = 8'h00;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {FILT_32, FILT_16, FILT_8, FILT_CLOSED} filter_mode_t;

	// One byte written into the background buffer by the bit engine.
	typedef struct packed {
		logic       valid;
		logic [3:0] index;
		logic [7:0] data;
	} rx_byte_t;

	// End-of-frame report from the bit engine.
	typedef struct packed {
		logic done;
		logic ok;
	} frame_status_t;

endpackage

//--- design/can_rx_fifo_filter.sv
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
module can_rx_fifo_filter
	import can_rx_pkg::*;
(
	// Clock, reset and enable.
	input  wire logic                clk_i,
	input  wire logic                reset_n_i,
	input  wire logic                ce_i,
	// AXI4-Lite write channels.
	input  wire logic                s_axi_awvalid_i,
	output logic                     s_axi_awready_o,
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr_i,
	input  wire logic                s_axi_wvalid_i,
	output logic                     s_axi_wready_o,
	input  wire logic [31:0]         s_axi_wdata_i,
	input  wire logic [3:0]          s_axi_wstrb_i,
	output logic                     s_axi_bvalid_o,
	input  wire logic                s_axi_bready_i,
	output logic [1:0]               s_axi_bresp_o,
	// AXI4-Lite read channels.
	input  wire logic                s_axi_arvalid_i,
	output logic                     s_axi_arready_o,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr_i,
	output logic                     s_axi_rvalid_o,
	input  wire logic                s_axi_rready_i,
	output logic [31:0]              s_axi_rdata_o,
	output logic [1:0]               s_axi_rresp_o,
	// Bit engine side.
	input  wire rx_byte_t            rx_byte_i,
	input  wire frame_status_t       frame_status_i,
	input  wire logic                tx_active_i,
	input  wire logic                tx_bit_i,
	input  wire logic [15:0]         time_stamp_i,
	input  wire logic [7:0]          rx_err_cnt_i,
	input  wire logic [7:0]          tx_err_cnt_i,
	// Status outputs.
	output logic                     tx_pin_o,
	output logic                     ack_enable_o,
	output logic                     rx_irq_o,
	output logic                     overrun_irq_o
);

	//======================================================================
	// Reset synchroniser
	//======================================================================
	logic rst_meta_reg;
	logic rst_n_reg;

	// Release is delayed two edges; assertion acts at once.
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			rst_meta_reg <= 1'b0;
			rst_n_reg    <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_n_reg    <= rst_meta_reg;
		end
	end

	//======================================================================
	// Storage
	//======================================================================
	logic [7:0] ctl0_reg;
	logic [7:0] ctl1_reg;
	logic [7:0] btr0_reg;
	logic [7:0] btr1_reg;
	logic [1:0] mode_reg;
	logic       overrun_reg;
	logic       init_ack_reg;
	logic       enable_written_reg;
	logic [7:0] pattern_reg [8];
	logic [7:0] mask_reg [8];
	logic [7:0] bg_reg [BUF_BYTES];
	logic [7:0] mem_reg [FIFO_DEPTH][BUF_BYTES];
	logic [2:0] hit_mem_reg [FIFO_DEPTH];
	logic [2:0] wr_ptr_reg;
	logic [2:0] rd_ptr_reg;
	logic [2:0] count_reg;

	//======================================================================
	// AXI4-Lite slave
	//======================================================================
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [7:0]        w_byte_reg;
	logic              w_lane0_reg;
	logic              do_write;
	logic              wr_ok;

	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		addr_mapped = (a[1:0] == 2'h0) && (a <= FG_LAST);
		if (a > ERRC_ADDR && a < PAT_BASE)
			addr_mapped = 1'b0;
	endfunction

	assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
	assign wr_ok    = do_write && w_lane0_reg && addr_mapped(aw_addr_reg);

	// Address and data are latched independently; the response follows both.
	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			aw_held_reg     <= 1'b0;
			w_held_reg      <= 1'b0;
			aw_addr_reg     <= '0;
			w_byte_reg      <= 8'h00;
			w_lane0_reg     <= 1'b0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (s_axi_awvalid_i && s_axi_awready_o)
			begin
				aw_held_reg     <= 1'b1;
				aw_addr_reg     <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o)
			begin
				w_held_reg     <= 1'b1;
				w_byte_reg     <= s_axi_wdata_i[7:0];
				w_lane0_reg    <= s_axi_wstrb_i[0];
				s_axi_wready_o <= 1'b0;
			end
			if (do_write)
			begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= addr_mapped(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i)
			begin
				s_axi_bvalid_o  <= 1'b0;
				aw_held_reg     <= 1'b0;
				w_held_reg      <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	logic [2:0] head_hit;

	// An empty queue reports no hit rather than a stale one from a popped frame.
	assign head_hit = (count_reg != 3'h0) ? hit_mem_reg[rd_ptr_reg] : 3'h0; // [R14]

	// Read data is assembled from registered state, except the error counters taken straight from the inputs.
	function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off       = a - FG_BASE;
		read_byte = 8'h00;
		if (a >= FG_BASE)
			read_byte = mem_reg[rd_ptr_reg][off[5:2]];
		else if (a >= MASK_BASE)
			read_byte = mask_reg[a[4:2]];
		else if (a >= PAT_BASE)
			read_byte = pattern_reg[a[4:2]];
		else
			case (a)
				CTL0_ADDR: read_byte = ctl0_reg;
				CTL1_ADDR: read_byte = {ctl1_reg[7:1], init_ack_reg};
				BTR0_ADDR: read_byte = btr0_reg;
				BTR1_ADDR: read_byte = btr1_reg;
				RFLG_ADDR: read_byte = {6'h00, overrun_reg, count_reg != 3'h0};
				IDAC_ADDR: read_byte = {2'h0, mode_reg, 1'b0, head_hit};
				default:   read_byte = 8'h00;
			endcase
	endfunction

	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= RESP_OKAY;
		end
		else if (ce_i)
		begin
			if (s_axi_arvalid_i && s_axi_arready_o)
			begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rresp_o   <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
				// A refused read returns zero so no stale head byte leaks out.
				if (!addr_mapped(s_axi_araddr_i))
					s_axi_rdata_o <= 32'h0000_0000;
				else if (s_axi_araddr_i == ERRC_ADDR)
					s_axi_rdata_o <= {16'h0000, tx_err_cnt_i, rx_err_cnt_i}; // [R19]
				else
					s_axi_rdata_o <= {24'h000000, read_byte(s_axi_araddr_i)};
			end
			else if (s_axi_rvalid_o && s_axi_rready_i)
			begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	//======================================================================
	// Control and configuration registers
	//======================================================================
	logic cfg_unlocked;
	logic in_init;
	logic online;

	assign cfg_unlocked = ctl0_reg[CTL0_INIT_REQ] && init_ack_reg; // [R20] [R23]
	assign in_init      = ctl0_reg[CTL0_INIT_REQ] || init_ack_reg;
	assign online       = ctl1_reg[CTL1_ENABLE] && !in_init && !ctl0_reg[CTL0_PWR_DOWN];

	// Init request may only be withdrawn once acknowledged.
	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			ctl0_reg           <= CTL0_RESET;
			ctl1_reg           <= CTL1_RESET;
			init_ack_reg       <= 1'b0;
			enable_written_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			init_ack_reg <= ctl0_reg[CTL0_INIT_REQ]; // [R23]
			if (wr_ok && aw_addr_reg == CTL0_ADDR)
			begin
				ctl0_reg[7:1] <= w_byte_reg[7:1];
				if (w_byte_reg[CTL0_INIT_REQ] || init_ack_reg)
					ctl0_reg[CTL0_INIT_REQ] <= w_byte_reg[CTL0_INIT_REQ];
			end
			if (wr_ok && aw_addr_reg == CTL1_ADDR)
			begin
				if (cfg_unlocked)
					ctl1_reg[6:1] <= w_byte_reg[6:1]; // [R20]
				if (!enable_written_reg)
				begin
					ctl1_reg[CTL1_ENABLE] <= w_byte_reg[CTL1_ENABLE]; // [R22]
					enable_written_reg    <= 1'b1;
				end
			end
		end
	end

	// Timing, filter mode, patterns and masks are locked outside init.
	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			btr0_reg <= CFG_RESET;
			btr1_reg <= CFG_RESET;
			mode_reg <= 2'h0;
			for (int i = 0; i < 8; i++)
			begin
				pattern_reg[i] <= CFG_RESET;
				mask_reg[i]    <= CFG_RESET;
			end
		end
		else if (ce_i && wr_ok && cfg_unlocked) // [R20]
		begin
			if (aw_addr_reg == BTR0_ADDR)
				btr0_reg <= w_byte_reg;
			if (aw_addr_reg == BTR1_ADDR)
				btr1_reg <= w_byte_reg;
			if (aw_addr_reg == IDAC_ADDR)
				mode_reg <= w_byte_reg[IDAC_MODE_LO +: 2];
			if (aw_addr_reg >= PAT_BASE && aw_addr_reg < MASK_BASE)
				pattern_reg[aw_addr_reg[4:2]] <= w_byte_reg; // [R13]
			if (aw_addr_reg >= MASK_BASE && aw_addr_reg < FG_BASE)
				mask_reg[aw_addr_reg[4:2]] <= w_byte_reg; // [R13]
		end
	end

	//======================================================================
	// Acceptance filter
	//======================================================================
	logic [7:0] cmp_own;
	logic [7:0] cmp_b0;
	logic [7:0] cmp_b1;
	logic [7:0] hits;
	logic [2:0] hit_index;
	logic       hit_any;

	// A mask bit of one excludes that identifier bit from the compare.
	function automatic logic byte_match(input logic [7:0] d, p, m);
		byte_match = ((d ^ p) & ~m) == 8'h00; // [R24]
	endfunction

	// Filter runs on the background buffer while it fills.
	generate
		for (genvar g = 0; g < 8; g++)
		begin : g_cmp
			assign cmp_own[g] = byte_match(bg_reg[g % 4], pattern_reg[g], mask_reg[g]); // [R4]
			assign cmp_b0[g]  = byte_match(bg_reg[0], pattern_reg[g], mask_reg[g]);
			assign cmp_b1[g]  = byte_match(bg_reg[1], pattern_reg[g], mask_reg[g]);
		end
	endgenerate

	// Lowest-numbered hit wins.
	always_comb
	begin
		hits = 8'h00;
		case (filter_mode_t'(mode_reg))
			FILT_32: hits = {6'h00, &cmp_own[7:4], &cmp_own[3:0]}; // [R15]
			FILT_16: hits = {4'h0, cmp_b0[6] & cmp_b1[7], cmp_b0[4] & cmp_b1[5],
			                 cmp_b0[2] & cmp_b1[3], cmp_b0[0] & cmp_b1[1]}; // [R16]
			FILT_8:  hits = cmp_b0; // [R17]
			default: hits = 8'h00; // [R18]
		endcase
		hit_index = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (hits[i])
				hit_index = 3'(i); // [R14]
		hit_any = |hits;
	end

	//======================================================================
	// Background buffer and receive queue
	//======================================================================
	logic frame_counts;
	logic push_req;
	logic push;
	logic pop;

	// Own frames count only when arbitration was lost or in loopback.
	assign frame_counts = !tx_active_i || ctl1_reg[CTL1_LOOPBACK]; // [R9] [R10]
	assign push_req = frame_status_i.done && frame_status_i.ok && hit_any
	                  && frame_counts && online; // [R8]
	assign push     = push_req && (count_reg != 3'(FIFO_DEPTH)); // [R12]
	assign pop      = wr_ok && aw_addr_reg == RFLG_ADDR
	                  && w_byte_reg[RFLG_RX_FULL] && count_reg != 3'h0; // [R6]

	function automatic logic [2:0] ptr_inc(input logic [2:0] p);
		ptr_inc = (p == 3'(FIFO_DEPTH - 1)) ? 3'h0 : p + 3'h1;
	endfunction

	// The engine overwrites bytes freely; a rejected frame is just replaced.
	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			for (int i = 0; i < BUF_BYTES; i++)
				bg_reg[i] <= 8'h00;
		end
		else if (ce_i && rx_byte_i.valid && rx_byte_i.index < 4'(BUF_BYTES))
			bg_reg[rx_byte_i.index] <= rx_byte_i.data; // [R2] [R4] [R7] [R8]
	end

	// Completed accepted frames are copied into the queue tail, bytes 13 and 14 replaced by the time stamp or zero.
	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			for (int e = 0; e < FIFO_DEPTH; e++)
			begin
				hit_mem_reg[e] <= 3'h0;
				for (int i = 0; i < BUF_BYTES; i++)
					mem_reg[e][i] <= 8'h00;
			end
		end
		else if (ce_i && push)
		begin
			for (int i = 0; i < BUF_BYTES; i++)
				mem_reg[wr_ptr_reg][i] <= bg_reg[i]; // [R1] [R5]
			mem_reg[wr_ptr_reg][TS_HI_BYTE] <= ctl1_reg[CTL1_TS_EN] ? time_stamp_i[15:8] : 8'h00;
			mem_reg[wr_ptr_reg][TS_LO_BYTE] <= ctl1_reg[CTL1_TS_EN] ? time_stamp_i[7:0] : 8'h00;
			hit_mem_reg[wr_ptr_reg] <= hit_index; // [R14]
		end
	end

	// Queue pointers; entering init empties the queue.
	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			wr_ptr_reg <= 3'h0;
			rd_ptr_reg <= 3'h0;
			count_reg  <= 3'h0;
		end
		else if (ce_i)
		begin
			if (init_ack_reg)
			begin
				wr_ptr_reg <= 3'h0;
				rd_ptr_reg <= 3'h0;
				count_reg  <= 3'h0;
			end
			else
			begin
				if (push)
					wr_ptr_reg <= ptr_inc(wr_ptr_reg);
				if (pop)
					rd_ptr_reg <= ptr_inc(rd_ptr_reg); // [R24]
				// Full flag is count nonzero, so a push in the clearing cycle survives.
				if (push && !pop)
					count_reg <= count_reg + 3'h1; // [R3] [R5]
				else if (pop && !push)
					count_reg <= count_reg - 3'h1; // [R6]
			end
		end
	end

	// Overrun is sticky; a new overrun beats a clear in the same cycle.
	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
			overrun_reg <= 1'b0;
		else if (ce_i)
		begin
			if (push_req && !push)
				overrun_reg <= 1'b1; // [R11]
			else if (init_ack_reg)
				overrun_reg <= 1'b0;
			else if (wr_ok && aw_addr_reg == RFLG_ADDR && w_byte_reg[RFLG_OVERRUN])
				overrun_reg <= 1'b0;
		end
	end

	//======================================================================
	// Pin and interrupt outputs
	//======================================================================
	logic force_recessive;

	// Forced from the same edge that writes the request, not one later.
	assign force_recessive = (wr_ok && aw_addr_reg == CTL0_ADDR)
	                         ? (w_byte_reg[CTL0_INIT_REQ] || w_byte_reg[CTL0_PWR_DOWN]
	                            || ctl0_reg[CTL0_INIT_REQ])
	                         : (in_init || ctl0_reg[CTL0_PWR_DOWN]);

	always_ff @(posedge clk_i or negedge rst_n_reg)
	begin
		if (!rst_n_reg)
		begin
			tx_pin_o      <= 1'b1;
			ack_enable_o  <= 1'b0;
			rx_irq_o      <= 1'b0;
			overrun_irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			tx_pin_o      <= force_recessive || !ctl1_reg[CTL1_ENABLE] || tx_bit_i; // [R21]
			ack_enable_o  <= online && frame_counts; // [R9]
			rx_irq_o      <= (count_reg != 3'h0) && ctl0_reg[CTL0_RX_IE]; // [R5]
			overrun_irq_o <= overrun_reg && ctl0_reg[CTL0_OVR_IE]; // [R11]
		end
	end

endmodule // can_rx_fifo_filter

//--- testbench/can_frame_model.sv
`timescale 1ns/1ns
module can_frame_model
	import can_rx_pkg::*;
(
	// Clock.
	input  wire logic     clk_i,
	// Bit engine side of the block.
	output rx_byte_t      rx_byte_o,
	output frame_status_t frame_status_o
);
	//==============================================================
	// Frame source
	// Idle strobes stay low between frames.
	initial
	begin
		rx_byte_o = '0;
		frame_status_o = '0;
	end

	// Identifier bytes come first so the filter can judge while bytes land.
	task automatic send(input logic [31:0] id, input logic [7:0] d, input logic ok);
		for (int j = 0; j < 13; j++)
		begin
			@(posedge clk_i);
			rx_byte_o <= '{1'b1, 4'(j), (j < 4) ? id[31-8*j -: 8] : (j < 12) ? d + 8'(j) : 8'h08};
		end
		@(posedge clk_i);
		rx_byte_o <= '0;
		frame_status_o <= '{1'b1, ok};
		@(posedge clk_i);
		frame_status_o <= '0;
	endtask
endmodule // can_frame_model

//--- testbench/can_rx_fifo_filter_asserts.sv
`timescale 1ns/1ns
module can_rx_fifo_filter_asserts
	import can_rx_pkg::*;
(
	// Clock and reset.
	input wire logic          clk_i,
	input wire logic          reset_n_i,
	// Bus channels.
	input wire logic          s_axi_awvalid_i,
	input wire logic          s_axi_awready_o,
	input wire logic          s_axi_wvalid_i,
	input wire logic          s_axi_wready_o,
	input wire logic          s_axi_bvalid_o,
	input wire logic          s_axi_bready_i,
	input wire logic [1:0]    s_axi_bresp_o,
	input wire logic          s_axi_arvalid_i,
	input wire logic          s_axi_arready_o,
	input wire logic          s_axi_rvalid_o,
	input wire logic          s_axi_rready_i,
	input wire logic [31:0]   s_axi_rdata_o,
	input wire logic [1:0]    s_axi_rresp_o,
	// Frame side.
	input wire frame_status_t frame_status_i,
	input wire logic          tx_bit_i,
	input wire logic          tx_pin_o,
	input wire logic          rx_irq_o
);
	//==============================================================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o)
		else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
		else $error("write not answered");
	a_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
		&& $stable(s_axi_rdata_o) && $stable(s_axi_rresp_o))
		else $error("read answer dropped");
	a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o
		&& $stable(s_axi_bresp_o))
		else $error("write answer dropped");
	a_write_busy: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
		else $error("write taken while answer pending");
	a_err_zero: assert property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR
		|-> s_axi_rdata_o == 32'h0)
		else $error("error read returned data");
	a_pin_driven: assert property (!tx_pin_o |-> !$past(tx_bit_i))
		else $error("dominant pin without dominant bit");
	a_irq_cause: assert property ($rose(rx_irq_o) |-> $past(frame_status_i.done && frame_status_i.ok, 2)
		|| $past(s_axi_wvalid_i && s_axi_wready_o, 2) || $past(s_axi_wvalid_i && s_axi_wready_o, 3)
		|| $past(s_axi_wvalid_i && s_axi_wready_o, 4))
		else $error("receive interrupt without accepted frame");

	// Main scenarios.
	c_frame_ok: cover property (frame_status_i.done && frame_status_i.ok);
	c_read_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == RESP_SLVERR);
	c_irq_rise: cover property ($rose(rx_irq_o));
endmodule // can_rx_fifo_filter_asserts

bind can_rx_fifo_filter can_rx_fifo_filter_asserts chk_u (
	.clk_i(clk_i), .reset_n_i(reset_n_i), .s_axi_awvalid_i(s_axi_awvalid_i),
	.s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
	.s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o),
	.s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
	.s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o),
	.s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
	.s_axi_rdata_o(s_axi_rdata_o), .s_axi_rresp_o(s_axi_rresp_o),
	.frame_status_i(frame_status_i), .tx_bit_i(tx_bit_i), .tx_pin_o(tx_pin_o),
	.rx_irq_o(rx_irq_o));

//--- testbench/can_rx_fifo_filter_tb.sv
`timescale 1ns/1ns
module can_rx_fifo_filter_tb
	import can_rx_pkg::*;
;
	//==============================================================
	// Signals
	localparam logic [31:0] ID_A = 32'hA1B2C3D4;
	localparam logic [31:0] ID_B = 32'h5E6F7081;
	logic          clk_i = 0;
	logic          reset_n_i = 0;
	logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0]    awaddr = '0, araddr = '0;
	logic [31:0]   wdata = '0, d;
	logic [1:0]    r;
	logic          tx_active = 0, tx_bit = 1;
	wire           awready, wready, bvalid, arready, rvalid, tx_pin, ack_en, rx_irq, ovr_irq;
	wire [1:0]     bresp, rresp;
	wire [31:0]    rdata;
	rx_byte_t      rx_byte;
	frame_status_t frame_status;
	int            num_errors = 0, cmp_count = 0;
	logic [63:0]   pats[3] = '{{16'hA1B3, 16'hA1B2, 32'h0}, {24'h0, 8'hA1, 8'h0, 8'hA1, 16'h0}, 64'h0};
	logic [63:0]   msks[3] = '{{32'h0, 32'hFFFFFFFF}, 64'h0, '1};

	// The clock runs at 10 MHz.
	always #50 clk_i = ~clk_i;

	can_frame_model frame_u (.clk_i(clk_i), .rx_byte_o(rx_byte), .frame_status_o(frame_status));

	can_rx_fifo_filter dut_u (
		.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
		.s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr),
		.s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_wdata_i(wdata),
		.s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_bresp_o(bresp), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_araddr_i(araddr), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .rx_byte_i(rx_byte),
		.frame_status_i(frame_status), .tx_active_i(tx_active), .tx_bit_i(tx_bit),
		.time_stamp_i(16'h1234), .rx_err_cnt_i(8'h5A), .tx_err_cnt_i(8'hA5),
		.tx_pin_o(tx_pin), .ack_enable_o(ack_en), .rx_irq_o(rx_irq), .overrun_irq_o(ovr_irq));

	//==============================================================
	// Tasks
	task automatic stop_test();
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Address and data are offered together; each is dropped when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		awvalid <= 1;
		awaddr <= a;
		wvalid <= 1;
		wdata <= v;
		bready <= 1;
		do
		begin
			@(posedge clk_i);
			if (awready)
				awvalid <= 0;
			if (wready)
				wvalid <= 0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		arvalid <= 1;
		araddr <= a;
		rready <= 1;
		do
		begin
			@(posedge clk_i);
			if (arready)
				arvalid <= 0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
	endtask

	// Reconfiguration needs acknowledged init mode; leaving it keeps both interrupts on.
	task automatic cfg(input logic [1:0] m, input logic [63:0] p, input logic [63:0] k);
		wr(CTL0_ADDR, 32'h0D);
		do
			rd(CTL1_ADDR);
		while (d[0] !== 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			wr(PAT_BASE + 8'(4*i), {24'h0, p[63-8*i -: 8]});
			wr(MASK_BASE + 8'(4*i), {24'h0, k[63-8*i -: 8]});
		end
		wr(IDAC_ADDR, {26'h0, m, 4'h0});
		wr(CTL0_ADDR, 32'h0C);
	endtask

	task automatic pop();
		wr(RFLG_ADDR, 32'h01);
	endtask

	//==============================================================
	// Main sequence
	initial
	begin
		repeat (12) @(posedge clk_i);
		reset_n_i <= 1;
		repeat (3) @(posedge clk_i);
		rd(CTL0_ADDR);
		chk("ctl0", 32'h01, d);
		rd(CTL1_ADDR);
		chk("ctl1", 32'h01, d);
		wr(ERRC_ADDR, 32'h0);
		rd(ERRC_ADDR);
		chk("err counters", 32'hA55A, d);
		rd(8'hFC);
		chk("unmapped resp", RESP_SLVERR, r);
		wr(8'h1C, 32'h0);
		chk("unmapped write", RESP_SLVERR, r);
		tx_bit <= 0;
		repeat (2) @(posedge clk_i);
		chk("pin in init", 1, tx_pin);
		wr(CTL1_ADDR, 32'h80);
		cfg(FILT_32, {ID_A, 32'h0}, {32'h0, 32'hFFFFFFFF});
		repeat (3) @(posedge clk_i);
		chk("pin online", 0, tx_pin);
		wr(PAT_BASE, 32'hFF);
		rd(PAT_BASE);
		chk("locked pattern", 32'hA1, d);
		chk("ack enable", 1, ack_en);
		frame_u.send(ID_A, 8'h10, 0);
		tx_active <= 1;
		frame_u.send(ID_A, 8'h20, 1);
		chk("ack own frame", 0, ack_en);
		tx_active <= 0;
		rd(RFLG_ADDR);
		chk("bad or own frame", 0, d);
		frame_u.send(ID_A, 8'h30, 1);
		frame_u.send(ID_B, 8'h40, 1);
		repeat (3) @(posedge clk_i);
		chk("rx irq", 1, rx_irq);
		rd(RFLG_ADDR);
		chk("rx full", 32'h01, d);
		rd(IDAC_ADDR);
		chk("hit both", 32'h00, d);
		rd(FG_BASE);
		chk("id byte", 32'hA1, d);
		rd(FG_BASE + 8'd16);
		chk("data byte", 32'h34, d);
		rd(FG_BASE + 8'd48);
		chk("length", 32'h08, d);
		rd(FG_BASE + 8'd52);
		chk("no stamp", 32'h00, d);
		pop();
		rd(IDAC_ADDR);
		chk("hit masked", 32'h01, d);
		rd(FG_BASE + 8'd16);
		chk("second data", 32'h44, d);
		pop();
		rd(RFLG_ADDR);
		chk("queue empty", 0, d);
		tx_active <= 1;
		fork
			frame_u.send(ID_A, 8'h50, 1);
			begin
				repeat (4) @(posedge clk_i);
				tx_active <= 0;
			end
		join
		rd(RFLG_ADDR);
		chk("lost arbitration", 32'h01, d);
		pop();
		for (int k = 0; k < 6; k++)
			frame_u.send(ID_A, 8'(16*k), 1);
		repeat (3) @(posedge clk_i);
		rd(RFLG_ADDR);
		chk("overrun", 32'h03, d);
		chk("overrun irq", 1, ovr_irq);
		rd(FG_BASE + 8'd16);
		chk("oldest", 32'h04, d);
		pop();
		frame_u.send(ID_A, 8'h60, 1);
		repeat (3) @(posedge clk_i);
		for (int k = 0; k < 5; k++)
		begin
			rd(FG_BASE + 8'd16);
			chk("queue order", (k < 4) ? 32'(16*k+20) : 32'h64, d);
			pop();
		end
		wr(RFLG_ADDR, 32'h02);
		rd(RFLG_ADDR);
		chk("flags cleared", 0, d);
		for (int m = 0; m < 3; m++)
		begin
			cfg(2'(m+1), pats[m], msks[m]);
			frame_u.send(ID_A, 8'h70, 1);
			repeat (3) @(posedge clk_i);
			rd(RFLG_ADDR);
			chk("mode full", (m < 2) ? 32'h01 : 32'h00, d);
			rd(IDAC_ADDR);
			chk("mode hit", {26'h0, 2'(m+1), 4'h0} | ((m == 0) ? 1 : (m == 1) ? 3 : 0), d);
			pop();
		end
		wr(CTL0_ADDR, 32'h01);
		repeat (3) @(posedge clk_i);
		chk("pin back in init", 1, tx_pin);
		wr(CTL1_ADDR, 32'h20);
		wr(IDAC_ADDR, 32'h20);
		rd(CTL1_ADDR);
		chk("enable once", 32'hA1, d);
		wr(CTL0_ADDR, 32'h00);
		tx_active <= 1;
		frame_u.send(ID_A, 8'h80, 1);
		chk("ack loopback", 1, ack_en);
		rd(RFLG_ADDR);
		chk("loopback frame", 32'h01, d);
		stop_test();
	end

	// Watchdog for a hung handshake.
	initial
	begin
		repeat (30000) @(posedge clk_i);
		num_errors++;
		stop_test();
	end
endmodule // can_rx_fifo_filter_tb
